//--- hw/lppb_consts.svh
// Purpose: Shared constants for the loop parallel port bridge
// Assumes: 25 MHz system clock
// Notes: Times in ns, cycle counts derived from them except LPPB_BUSY_CYC
`ifndef LPPB_CONSTS_SVH
`define LPPB_CONSTS_SVH

// ==========================================================
// Clock and timing
`define LPPB_CLK_MHZ 25
`define LPPB_PULSE_NS 2000
`define LPPB_PULSE_CYC ((`LPPB_PULSE_NS * `LPPB_CLK_MHZ + 999) / 1000)
`define LPPB_WAKE_NS 200
`define LPPB_WAKE_CYC ((`LPPB_WAKE_NS * `LPPB_CLK_MHZ + 999) / 1000)
`define LPPB_WAKE_COUNT 3
`define LPPB_STROBE_NS 400
`define LPPB_STROBE_CYC ((`LPPB_STROBE_NS * `LPPB_CLK_MHZ + 999) / 1000)
`define LPPB_BUSY_CYC 8

// ==========================================================
// Buffer and registers
`define LPPB_FIFO_DEPTH 32
`define LPPB_FIFO_WIDTH 8
`define LPPB_NUM_CREGS 19

// ==========================================================
// Control register fields
`define LPPB_R00_SRQ_EN 6
`define LPPB_R01_PA_BIDIR 0
`define LPPB_R01_PB_BIDIR 1
`define LPPB_R01_OMODE_LO 2
`define LPPB_R01_OMODE_HI 3
`define LPPB_R02_NEG 4

// ==========================================================
// Power-up defaults
`define LPPB_R00_DEF 8'h40
`define LPPB_R01_DEF 8'h00
`define LPPB_R02_DEF 8'h00
`define LPPB_RXX_DEF 8'h00

`endif

//--- hw/lppb_device.sv
// Purpose: Bridge end of the parallel port: buffer, config, handshakes
// Assumes: Loop message engine outside, delivers decoded messages
// Notes: Wake logic runs on the system clock; unpowered operation is board level
`timescale 1ns/100ps

// ==========================================================
// Transfer buffer
module lppb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic FLUSH,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [WIDTH-1:0] IN_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [WIDTH-1:0] OUT_DATA
);
  import lppb_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } lppb_fifo_st_t;
  lppb_fifo_st_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign IN_READY = q.cnt != (AW+1)'(DEPTH);
  assign OUT_VALID = q.cnt != '0;
  assign OUT_DATA = mem[q.rd];
  assign push = IN_VALID & IN_READY;
  assign pop = OUT_VALID & OUT_READY;

  always_comb begin
    d = q;
    d.wr = q.wr + AW'(push);
    d.rd = q.rd + AW'(pop);
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (FLUSH) begin
      d = '0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage needs no reset, pointers guard it
  always_ff @(posedge CLK_SYS) begin
    if (push) begin
      mem[q.wr] <= IN_DATA;
    end
  end
endmodule : lppb_fifo

// ==========================================================
// Active-low event pulse
module lppb_pulse (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic FIRE,
  output logic PULSE_N
);
  import lppb_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;
    logic n;
  } lppb_pulse_st_t;
  lppb_pulse_st_t q, d;

  always_comb begin
    d = q;
    if (FIRE) begin
      d.cnt = 8'(`LPPB_PULSE_CYC);
    end else if (q.cnt != 8'h00) begin
      d.cnt = q.cnt - 8'h01;
    end
    d.n = (d.cnt == 8'h00);
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      q <= '{cnt: 8'h00, n: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign PULSE_N = q.n;
endmodule : lppb_pulse

// ==========================================================
// Bridge end
module lppb_device (
  input wire logic CLK_SYS,
  input wire logic RST,
  lppb_gpio_if.dev g,
  input wire logic MSG_VALID,
  input wire lppb_pkg::lppb_msg_t MSG_CODE,
  input wire logic CFG_WR,
  input wire logic [4:0] CFG_IDX,
  input wire logic [7:0] CFG_DATA,
  output logic CFG_READY,
  input wire logic LOOP_RX_VALID,
  input wire logic [7:0] LOOP_RX_DATA,
  output logic LOOP_RX_READY,
  output logic LOOP_TX_VALID,
  output logic [7:0] LOOP_TX_DATA,
  input wire logic LOOP_TX_READY,
  output logic [7:0] STATUS,
  output logic SRQ_FLAG,
  output logic IS_TALKER,
  output logic IS_LISTENER,
  output logic ADDR_VALID
);
  import lppb_pkg::*;
  localparam lppb_dev_t DEV_RST = lppb_dev_t'({LPPB_CREG_DEF, {($bits(lppb_dev_t) - $bits(lppb_cregs_t)){1'b0}}});

  lppb_dev_t q, d;
  lppb_omode_t omode;
  logic neg, rdy_t, acc_t, val_t, srq_t, uses_rdy, uses_acc, busy, msg_ok;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, flush;
  logic [7:0] f_in_data, f_out_data;
  logic fire_dcl, fire_get, fire_pwd;

  assign neg = q.creg[2][`LPPB_R02_NEG];
  assign omode = lppb_omode_t'(q.creg[1][`LPPB_R01_OMODE_HI:`LPPB_R01_OMODE_LO]);
  assign uses_rdy = (omode == LPPB_OM_FULL) || (omode == LPPB_OM_NO_ACK);
  assign uses_acc = (omode == LPPB_OM_FULL) || (omode == LPPB_OM_NO_RDY);
  assign rdy_t = q.rdy_s[1] ^ neg;
  assign acc_t = q.acc_s[1] ^ neg;
  assign val_t = q.val_s[1] ^ neg;
  // Synchroniser holds the inverted pin so its reset value means idle
  assign srq_t = q.srq_s[1] & q.creg[0][`LPPB_R00_SRQ_EN];
  assign busy = q.busy_cnt != 4'h0;
  assign msg_ok = MSG_VALID & (q.addr_ok | (MSG_CODE == LPPB_MSG_ADDR_SET));
  assign flush = msg_ok & (MSG_CODE inside {LPPB_MSG_IFC, LPPB_MSG_LAD_ME, LPPB_MSG_TAD_ME});

  // Shared buffer, direction set by talker or listener role
  assign f_in_valid = q.listener ? LOOP_RX_VALID : (q.talker & (q.ist == LPPB_I_IDLE) & val_t);
  assign f_in_data = q.listener ? LOOP_RX_DATA : g.primary_data_bus;
  assign f_out_ready = q.listener ? ((q.ost == LPPB_O_IDLE) & ~busy & (rdy_t | ~uses_rdy) & ~(uses_acc & acc_t))
                                  : (q.talker & LOOP_TX_READY);
  assign LOOP_RX_READY = q.listener & f_in_ready;
  assign LOOP_TX_VALID = q.talker & f_out_valid;
  assign LOOP_TX_DATA = f_out_data;
  assign CFG_READY = q.addr_ok & ~busy & (q.ost == LPPB_O_IDLE);

  lppb_fifo #(.WIDTH(`LPPB_FIFO_WIDTH), .DEPTH(`LPPB_FIFO_DEPTH)) u_buf (
    .CLK_SYS(CLK_SYS), .RST(RST), .FLUSH(flush),
    .IN_VALID(f_in_valid), .IN_READY(f_in_ready), .IN_DATA(f_in_data),
    .OUT_VALID(f_out_valid), .OUT_READY(f_out_ready), .OUT_DATA(f_out_data)
  );

  assign fire_dcl = msg_ok & ((MSG_CODE == LPPB_MSG_DCL) | ((MSG_CODE == LPPB_MSG_SDC) & q.listener));
  assign fire_get = msg_ok & (MSG_CODE == LPPB_MSG_GET);
  assign fire_pwd = msg_ok & (MSG_CODE == LPPB_MSG_LPD);
  lppb_pulse u_dcl (.CLK_SYS(CLK_SYS), .RST(RST), .FIRE(fire_dcl), .PULSE_N(g.device_clear_pulse_n));
  lppb_pulse u_get (.CLK_SYS(CLK_SYS), .RST(RST), .FIRE(fire_get), .PULSE_N(g.trigger_pulse_n));
  lppb_pulse u_pwd (.CLK_SYS(CLK_SYS), .RST(RST), .FIRE(fire_pwd), .PULSE_N(g.power_down_pulse_n));

  always_comb begin
    d = q;
    d.rdy_s = {q.rdy_s[0], g.output_ready_in};
    d.acc_s = {q.acc_s[0], g.output_accepted_in};
    d.val_s = {q.val_s[0], g.input_valid_in};
    d.srq_s = {q.srq_s[0], ~g.manual_service_request_n};
    // Wake burst restarts on each message, even before an address
    if (MSG_VALID) begin
      d.wake_left = 3'(2 * `LPPB_WAKE_COUNT);
      d.wake_tmr = 8'(`LPPB_WAKE_CYC - 1);
    end else if (q.wake_left != 3'h0) begin
      if (q.wake_tmr == 8'h00) begin
        d.wake_left = q.wake_left - 3'h1;
        d.wake_tmr = 8'(`LPPB_WAKE_CYC - 1);
      end else begin
        d.wake_tmr = q.wake_tmr - 8'h01;
      end
    end
    if (msg_ok) begin
      unique case (MSG_CODE)
        LPPB_MSG_IFC: begin
          d.talker = 1'b0;
          d.listener = 1'b0;
        end
        LPPB_MSG_LAD_ME: begin
          d.listener = 1'b1;
          d.talker = 1'b0;
        end
        LPPB_MSG_UNL: d.listener = 1'b0;
        LPPB_MSG_TAD_ME: begin
          d.talker = 1'b1;
          d.listener = 1'b0;
        end
        LPPB_MSG_TAD_OTHER: d.talker = 1'b0;
        LPPB_MSG_ADDR_SET: d.addr_ok = 1'b1;
        default: ;
      endcase
    end
    // Config writes borrow the secondary bus for a while
    if (busy) begin
      d.busy_cnt = q.busy_cnt - 4'h1;
    end
    if (CFG_WR & CFG_READY & (CFG_IDX < 5'(`LPPB_NUM_CREGS))) begin
      d.creg[CFG_IDX] = CFG_DATA;
      d.busy_cnt = 4'(`LPPB_BUSY_CYC);
      d.ib_data = CFG_DATA;
    end
    unique case (q.ost)
      LPPB_O_IDLE: begin
        if (q.listener & f_out_valid & f_out_ready) begin
          d.odata = f_out_data;
          d.tmr = 8'(`LPPB_STROBE_CYC - 1);
          d.ost = LPPB_O_VALID;
        end
      end
      LPPB_O_VALID: begin
        d.tmr = (q.tmr == 8'h00) ? q.tmr : q.tmr - 8'h01;
        if (uses_acc ? acc_t : (q.tmr == 8'h00)) begin
          d.tmr = 8'(`LPPB_STROBE_CYC - 1);
          d.ost = LPPB_O_RELEASE;
        end
      end
      LPPB_O_RELEASE: begin
        d.tmr = (q.tmr == 8'h00) ? q.tmr : q.tmr - 8'h01;
        if (uses_acc ? ~acc_t : (q.tmr == 8'h00)) begin
          d.ost = LPPB_O_IDLE;
        end
      end
      default: d.ost = LPPB_O_IDLE;
    endcase
    unique case (q.ist)
      LPPB_I_IDLE: begin
        if (f_in_valid & f_in_ready & ~q.listener) begin
          d.ist = LPPB_I_ACK;
        end
      end
      LPPB_I_ACK: begin
        if (~val_t) begin
          d.ist = LPPB_I_IDLE;
        end
      end
    endcase
    if (~d.talker) begin
      d.ist = LPPB_I_IDLE;
    end
    d.status = {srq_t, d.talker, d.listener, d.addr_ok, ~f_in_ready, ~f_out_valid, omode};
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  // ========================================================
  // Pins
  assign g.output_valid_out = (q.ost == LPPB_O_VALID) ^ neg;
  assign g.input_ready_out = (q.talker & (q.ist == LPPB_I_IDLE) & f_in_ready) ^ neg;
  assign g.input_accepted_out = (q.ist == LPPB_I_ACK) ^ neg;
  assign g.dev_pa_oe = q.creg[1][`LPPB_R01_PA_BIDIR] & q.listener;
  assign g.dev_pa_out = (q.ost == LPPB_O_VALID) ? q.odata : 8'hFF;
  assign g.dev_pb_oe = busy | q.listener | ~q.creg[1][`LPPB_R01_PB_BIDIR];
  assign g.dev_pb_out = busy ? q.ib_data : ((q.ost == LPPB_O_VALID) ? q.odata : 8'hFF);
  assign g.internal_bus_busy_n = ~busy;
  assign g.wake_pulse_out = q.wake_left[0];
  assign g.handshake_polarity_out = neg;
  assign STATUS = q.status;
  assign SRQ_FLAG = srq_t;
  assign IS_TALKER = q.talker;
  assign IS_LISTENER = q.listener;
  assign ADDR_VALID = q.addr_ok;
endmodule : lppb_device

//--- hw/lppb_gpio_if.sv
// Purpose: Parallel link between the bridge and the external device
// Assumes: Both ends clocked from the same system clock
// Notes: Pull-ups modelled by AND of the drivers, idle level high
`timescale 1ns/100ps
interface lppb_gpio_if;
  logic [7:0] dev_pa_out;
  logic dev_pa_oe;
  logic [7:0] host_pa_out;
  logic host_pa_oe;
  logic [7:0] dev_pb_out;
  logic dev_pb_oe;
  logic [7:0] host_pb_out;
  logic host_pb_oe;
  logic [7:0] primary_data_bus;
  logic [7:0] secondary_data_bus;
  logic output_ready_in;
  logic output_valid_out;
  logic output_accepted_in;
  logic input_ready_out;
  logic input_valid_in;
  logic input_accepted_out;
  logic manual_service_request_n;
  logic device_clear_pulse_n;
  logic trigger_pulse_n;
  logic power_down_pulse_n;
  logic wake_pulse_out;
  logic handshake_polarity_out;
  logic internal_bus_busy_n;

  assign primary_data_bus = (dev_pa_oe ? dev_pa_out : 8'hFF) & (host_pa_oe ? host_pa_out : 8'hFF);
  assign secondary_data_bus = (dev_pb_oe ? dev_pb_out : 8'hFF) & (host_pb_oe ? host_pb_out : 8'hFF);

  modport dev (
    output dev_pa_out, dev_pa_oe, dev_pb_out, dev_pb_oe,
    input primary_data_bus, secondary_data_bus,
    input output_ready_in, output_accepted_in, input_valid_in, manual_service_request_n,
    output output_valid_out, input_ready_out, input_accepted_out,
    output device_clear_pulse_n, trigger_pulse_n, power_down_pulse_n, wake_pulse_out,
    output handshake_polarity_out, internal_bus_busy_n
  );

  modport host (
    output host_pa_out, host_pa_oe, host_pb_out, host_pb_oe,
    input primary_data_bus, secondary_data_bus,
    output output_ready_in, output_accepted_in, input_valid_in, manual_service_request_n,
    input output_valid_out, input_ready_out, input_accepted_out,
    input device_clear_pulse_n, trigger_pulse_n, power_down_pulse_n, wake_pulse_out,
    input handshake_polarity_out, internal_bus_busy_n
  );
endinterface : lppb_gpio_if

//--- hw/lppb_host.sv
// Purpose: External parallel device end of the link
// Assumes: Same system clock as the bridge, inputs synchronised here
// Notes: Always runs the full handshake, which suits all four output methods
`timescale 1ns/100ps
module lppb_host (
  input wire logic CLK_SYS,
  input wire logic RST,
  lppb_gpio_if.host g,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  output logic TX_READY,
  output logic RX_VALID,
  output logic [7:0] RX_DATA,
  input wire logic SRQ_REQ,
  output logic CLEAR_SEEN,
  output logic TRIGGER_SEEN,
  output logic POWER_DOWN_SEEN,
  output logic WAKE_SEEN
);
  import lppb_pkg::*;
  lppb_host_t q, d;
  logic neg, val_t, acc_t, rdy_t, free;

  // Sync slots: 0 valid, 1 accepted, 2 ready, 3 busy_n, 4 clear, 5 trigger, 6 power down, 7 wake, 8 polarity
  assign neg = q.s1[8];
  assign val_t = q.s1[0] ^ neg;
  assign acc_t = q.s1[1] ^ neg;
  assign rdy_t = q.s1[2] ^ neg;
  assign free = q.s1[3];
  assign TX_READY = (q.tx == LPPB_HT_IDLE) & rdy_t & ~acc_t;

  always_comb begin
    d = q;
    d.s0 = {g.handshake_polarity_out, g.wake_pulse_out, g.power_down_pulse_n, g.trigger_pulse_n,
            g.device_clear_pulse_n, g.internal_bus_busy_n, g.input_ready_out, g.input_accepted_out,
            g.output_valid_out};
    d.s1 = q.s0;
    d.prev = {q.s1[7], ~q.s1[6], ~q.s1[5], ~q.s1[4]};
    d.ev = {q.s1[7], ~q.s1[6], ~q.s1[5], ~q.s1[4]} & ~q.prev;
    d.srq_n = ~SRQ_REQ;
    d.rx_valid = 1'b0;
    unique case (q.rx)
      LPPB_HR_IDLE: begin
        // Bus only trusted while the bridge is not using it internally
        if (val_t & free) begin
          d.rx_data = g.secondary_data_bus;
          d.rx_valid = 1'b1;
          d.rx = LPPB_HR_ACK;
        end
      end
      LPPB_HR_ACK: begin
        if (~val_t) begin
          d.rx = LPPB_HR_IDLE;
        end
      end
    endcase
    unique case (q.tx)
      LPPB_HT_IDLE: begin
        if (TX_VALID & TX_READY) begin
          d.tx_data = TX_DATA;
          d.tx = LPPB_HT_DRIVE;
        end
      end
      LPPB_HT_DRIVE: begin
        if (acc_t) begin
          d.tx = LPPB_HT_WAIT;
        end
      end
      LPPB_HT_WAIT: begin
        if (~acc_t) begin
          d.tx = LPPB_HT_IDLE;
        end
      end
      default: d.tx = LPPB_HT_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      // Sync stages start at the idle pin levels, so no false event follows reset
      q <= '{s0: 9'h078, s1: 9'h078, prev: 4'h0, rx: LPPB_HR_IDLE, tx: LPPB_HT_IDLE, rx_data: 8'h00,
             rx_valid: 1'b0, tx_data: 8'h00, srq_n: 1'b1, ev: 4'h0};
    end else begin
      q <= d;
    end
  end

  assign g.output_ready_in = (q.rx == LPPB_HR_IDLE) ^ neg;
  assign g.output_accepted_in = (q.rx == LPPB_HR_ACK) ^ neg;
  assign g.input_valid_in = (q.tx == LPPB_HT_DRIVE) ^ neg;
  assign g.host_pa_oe = q.tx == LPPB_HT_DRIVE;
  assign g.host_pa_out = q.tx_data;
  // Never drives the secondary bus, so internal traffic is never disturbed
  assign g.host_pb_oe = 1'b0;
  assign g.host_pb_out = 8'hFF;
  assign g.manual_service_request_n = q.srq_n;
  assign RX_VALID = q.rx_valid;
  assign RX_DATA = q.rx_data;
  assign CLEAR_SEEN = q.ev[0];
  assign TRIGGER_SEEN = q.ev[1];
  assign POWER_DOWN_SEEN = q.ev[2];
  assign WAKE_SEEN = q.ev[3];
endmodule : lppb_host

//--- hw/lppb_pkg.sv
// Purpose: Types for the loop parallel port bridge
// Assumes: lppb_consts.svh on the include path
// Notes: Message codes arrive already decoded by the loop engine
package lppb_pkg;
  `include "lppb_consts.svh"

  typedef enum logic [3:0] {
    LPPB_MSG_NONE, LPPB_MSG_IFC, LPPB_MSG_DCL, LPPB_MSG_SDC, LPPB_MSG_GET,
    LPPB_MSG_LPD, LPPB_MSG_LAD_ME, LPPB_MSG_UNL, LPPB_MSG_TAD_ME,
    LPPB_MSG_TAD_OTHER, LPPB_MSG_ADDR_SET, LPPB_MSG_OTHER
  } lppb_msg_t;

  typedef enum logic [1:0] {
    LPPB_OM_FULL, LPPB_OM_NO_ACK, LPPB_OM_NO_RDY, LPPB_OM_STROBE
  } lppb_omode_t;

  typedef enum logic [1:0] {LPPB_O_IDLE, LPPB_O_VALID, LPPB_O_RELEASE} lppb_ostate_t;
  typedef enum logic {LPPB_I_IDLE, LPPB_I_ACK} lppb_istate_t;
  typedef enum logic {LPPB_HR_IDLE, LPPB_HR_ACK} lppb_hrx_t;
  typedef enum logic [1:0] {LPPB_HT_IDLE, LPPB_HT_DRIVE, LPPB_HT_WAIT} lppb_htx_t;

  typedef logic [`LPPB_NUM_CREGS-1:0][7:0] lppb_cregs_t;

  localparam lppb_cregs_t LPPB_CREG_DEF = {
    {(`LPPB_NUM_CREGS - 3){`LPPB_RXX_DEF}}, `LPPB_R02_DEF, `LPPB_R01_DEF, `LPPB_R00_DEF
  };

  typedef struct packed {
    lppb_cregs_t creg;
    logic talker;
    logic listener;
    logic addr_ok;
    lppb_ostate_t ost;
    lppb_istate_t ist;
    logic [7:0] odata;
    logic [7:0] tmr;
    logic [1:0] rdy_s;
    logic [1:0] acc_s;
    logic [1:0] val_s;
    logic [1:0] srq_s;
    logic [2:0] wake_left;
    logic [7:0] wake_tmr;
    logic [3:0] busy_cnt;
    logic [7:0] ib_data;
    logic [7:0] status;
  } lppb_dev_t;

  typedef struct packed {
    logic [8:0] s0;
    logic [8:0] s1;
    logic [3:0] prev;
    lppb_hrx_t rx;
    lppb_htx_t tx;
    logic [7:0] rx_data;
    logic rx_valid;
    logic [7:0] tx_data;
    logic srq_n;
    logic [3:0] ev;
  } lppb_host_t;
endpackage : lppb_pkg

//--- sim/lppb_link_asserts.sv
// Purpose: Link checks for the loop parallel port bridge
// Assumes: One clock, reset asynchronous active high
// Notes: Handshake truth is pin XOR polarity pin
`timescale 1ns/100ps
module lppb_link_asserts (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] secondary_data_bus,
  input wire logic host_pb_oe,
  input wire logic output_valid_out,
  input wire logic output_accepted_in,
  input wire logic input_ready_out,
  input wire logic input_valid_in,
  input wire logic input_accepted_out,
  input wire logic device_clear_pulse_n,
  input wire logic trigger_pulse_n,
  input wire logic power_down_pulse_n,
  input wire logic wake_pulse_out,
  input wire logic handshake_polarity_out,
  input wire logic internal_bus_busy_n
);
  logic ov, oa, ir, iv, ia, st, pol_q;
  logic [7:0] low_q;
  assign ov = output_valid_out ^ handshake_polarity_out;
  assign oa = output_accepted_in ^ handshake_polarity_out;
  assign ir = input_ready_out ^ handshake_polarity_out;
  assign iv = input_valid_in ^ handshake_polarity_out;
  assign ia = input_accepted_out ^ handshake_polarity_out;
  // Polarity flips make the host-driven truth values oa and iv glitch
  assign st = pol_q == handshake_polarity_out;
  // ==========================================================
  // Low time of any event pin
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      low_q <= 8'h00;
      pol_q <= 1'b0;
    end else begin
      low_q <= (device_clear_pulse_n & trigger_pulse_n & power_down_pulse_n) ? 8'h00 : low_q + 8'h01;
      pol_q <= handshake_polarity_out;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence wake_high;
    wake_pulse_out [*5];
  endsequence
  sequence wake_low;
    !wake_pulse_out [*5];
  endsequence
  a_idle_bus_high: assert property (st && !ov && internal_bus_busy_n |-> secondary_data_bus == 8'hFF)
    else $error("data lines not high while valid false");
  a_busy_bus_free: assert property (!internal_bus_busy_n |-> !host_pb_oe)
    else $error("far end drives secondary bus while busy");
  a_busy_span: assert property ($fell(internal_bus_busy_n) |-> !internal_bus_busy_n [*8] ##1 internal_bus_busy_n)
    else $error("busy low time wrong");
  a_pulse_width: assert property ($rose(device_clear_pulse_n & trigger_pulse_n & power_down_pulse_n) |-> low_q == 8'h32)
    else $error("event pulse width wrong");
  a_wake_burst: assert property ($rose(wake_pulse_out) |-> wake_high ##1 wake_low)
    else $error("wake pulse shape wrong");
  a_out_release: assert property (st && $fell(ov) |-> oa)
    else $error("valid dropped before accepted");
  a_in_sync_delay: assert property (st && $rose(iv) |-> !ia [*3])
    else $error("input accepted too early");
  a_in_ack_valid: assert property (st && $rose(ia) |-> iv)
    else $error("accepted without valid");
  a_in_ready_off: assert property (st && ia |-> !ir)
    else $error("ready while accepting");
endmodule : lppb_link_asserts

//--- sim/lppb_tb_top.sv
// Purpose: Self-checking bench for both ends of the parallel link
// Assumes: Both ends on one 25 MHz clock
// Notes: Host end always runs the full handshake
`timescale 1ns/100ps
module lppb_tb_top;
  import lppb_pkg::*;
  logic clk, rst, msg_v, cfg_wr, cfg_rdy, rx_v, rx_rdy, tx_v, tx_rdy, srq_f, is_t, is_l, addr_v;
  logic h_tx_v, h_tx_rdy, h_rx_v, srq_req, clr_s, trg_s, pwd_s, wake_s;
  logic [7:0] cfg_d, rx_d, tx_d, status, h_tx_d, h_rx_d;
  logic [4:0] cfg_idx;
  lppb_msg_t msg_c;
  logic [7:0] txq[$], rxq[$];
  int fails = 0, tests_run = 0, n_clr = 0, n_trg = 0, n_pwd = 0, n_wake = 0;

  lppb_gpio_if lppb_gpio_if_inst ();
  lppb_device lppb_device_inst (.CLK_SYS(clk), .RST(rst), .g(lppb_gpio_if_inst), .MSG_VALID(msg_v), .MSG_CODE(msg_c),
    .CFG_WR(cfg_wr), .CFG_IDX(cfg_idx), .CFG_DATA(cfg_d), .CFG_READY(cfg_rdy), .LOOP_RX_VALID(rx_v),
    .LOOP_RX_DATA(rx_d), .LOOP_RX_READY(rx_rdy), .LOOP_TX_VALID(tx_v), .LOOP_TX_DATA(tx_d), .LOOP_TX_READY(tx_rdy),
    .STATUS(status), .SRQ_FLAG(srq_f), .IS_TALKER(is_t), .IS_LISTENER(is_l), .ADDR_VALID(addr_v));
  lppb_host lppb_host_inst (.CLK_SYS(clk), .RST(rst), .g(lppb_gpio_if_inst), .TX_VALID(h_tx_v), .TX_DATA(h_tx_d),
    .TX_READY(h_tx_rdy), .RX_VALID(h_rx_v), .RX_DATA(h_rx_d), .SRQ_REQ(srq_req), .CLEAR_SEEN(clr_s),
    .TRIGGER_SEEN(trg_s), .POWER_DOWN_SEEN(pwd_s), .WAKE_SEEN(wake_s));
  lppb_link_asserts lppb_link_asserts_inst (.CLK_SYS(clk), .RST(rst),
    .secondary_data_bus(lppb_gpio_if_inst.secondary_data_bus), .host_pb_oe(lppb_gpio_if_inst.host_pb_oe),
    .output_valid_out(lppb_gpio_if_inst.output_valid_out), .output_accepted_in(lppb_gpio_if_inst.output_accepted_in),
    .input_ready_out(lppb_gpio_if_inst.input_ready_out), .input_valid_in(lppb_gpio_if_inst.input_valid_in),
    .input_accepted_out(lppb_gpio_if_inst.input_accepted_out),
    .device_clear_pulse_n(lppb_gpio_if_inst.device_clear_pulse_n), .trigger_pulse_n(lppb_gpio_if_inst.trigger_pulse_n),
    .power_down_pulse_n(lppb_gpio_if_inst.power_down_pulse_n), .wake_pulse_out(lppb_gpio_if_inst.wake_pulse_out),
    .handshake_polarity_out(lppb_gpio_if_inst.handshake_polarity_out),
    .internal_bus_busy_n(lppb_gpio_if_inst.internal_bus_busy_n));

  always #20 clk = ~clk;
  // Pulses are one cycle wide, so they are tallied here
  always @(posedge clk) begin
    if (clr_s === 1'b1) n_clr++;
    if (trg_s === 1'b1) n_trg++;
    if (pwd_s === 1'b1) n_pwd++;
    if (wake_s === 1'b1) n_wake++;
    if (h_rx_v === 1'b1) rxq.push_back(h_rx_d);
    if (tx_v === 1'b1 && tx_rdy === 1'b1) txq.push_back(tx_d);
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Returns at the edge where the flag is sampled high
  task automatic until_hi(ref logic s);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    do begin
      @(negedge clk);
      ok = (s === 1'b1);
      @(posedge clk);
      n++;
    end while (!ok && n < 400);
    if (!ok) begin
      chk(8'h00, 8'h01);
      finish_test();
    end
  endtask : until_hi

  // Spaced so pulses and wake bursts never restart
  task automatic msg(input lppb_msg_t c);
    msg_v <= 1'b1;
    msg_c <= c;
    @(posedge clk);
    msg_v <= 1'b0;
    cyc(60);
  endtask : msg

  task automatic cfg(input logic [4:0] i, input logic [7:0] d);
    cfg_wr <= 1'b1;
    cfg_idx <= i;
    cfg_d <= d;
    until_hi(cfg_rdy);
    cfg_wr <= 1'b0;
    @(negedge clk);
    chk(lppb_gpio_if_inst.secondary_data_bus, d);
    chk(8'(lppb_gpio_if_inst.internal_bus_busy_n), 8'h00);
    cyc(12);
  endtask : cfg

  // ==========================================================
  // Scenarios
  task automatic t_start();
    cyc(2);
    chk(status, 8'h04);
    chk(8'(lppb_gpio_if_inst.handshake_polarity_out), 8'h00);
    chk(8'(addr_v), 8'h00);
    msg(LPPB_MSG_DCL);
    chk(8'(n_clr), 8'h00);
    chk(8'(n_wake), 8'h03);
  endtask : t_start

  task automatic t_events();
    lppb_msg_t seq[6] = '{LPPB_MSG_DCL, LPPB_MSG_SDC, LPPB_MSG_GET, LPPB_MSG_LPD, LPPB_MSG_UNL, LPPB_MSG_SDC};
    msg(LPPB_MSG_ADDR_SET);
    chk(8'(addr_v), 8'h01);
    msg(LPPB_MSG_LAD_ME);
    chk(8'(is_l), 8'h01);
    foreach (seq[k]) msg(seq[k]);
    chk(8'(n_clr), 8'h02);
    chk(8'(n_trg), 8'h01);
    chk(8'(n_pwd), 8'h01);
    chk(8'(n_wake), 8'd27);
  endtask : t_events

  task automatic t_out();
    msg(LPPB_MSG_LAD_ME);
    for (int m = 0; m < 4; m++) begin
      cfg(5'h01, 8'(m << 2));
      rxq.delete();
      rx_v <= 1'b1;
      rx_d <= 8'hA0 + 8'(m);
      until_hi(rx_rdy);
      rx_d <= 8'h50 + 8'(m);
      until_hi(rx_rdy);
      rx_v <= 1'b0;
      for (int n = 0; n < 400 && rxq.size() < 2; n++) @(posedge clk);
      chk(8'(rxq.size()), 8'h02);
      chk(rxq[0], 8'hA0 + 8'(m));
      chk(rxq[1], 8'h50 + 8'(m));
    end
  endtask : t_out

  task automatic t_in();
    msg(LPPB_MSG_TAD_ME);
    chk(8'(is_t), 8'h01);
    txq.delete();
    h_tx_v <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      h_tx_d <= 8'(i) ^ 8'hC3;
      until_hi(h_tx_rdy);
    end
    h_tx_v <= 1'b0;
    cyc(20);
    chk(status & 8'h0C, 8'h08);
    chk(8'(lppb_gpio_if_inst.input_ready_out), 8'h00);
    tx_rdy <= 1'b1;
    for (int n = 0; n < 400 && txq.size() < 32; n++) @(posedge clk);
    chk(8'(txq.size()), 8'h20);
    foreach (txq[i]) chk(txq[i], 8'(i) ^ 8'hC3);
    cyc(2);
    chk(status & 8'h0C, 8'h04);
  endtask : t_in

  task automatic t_cfg();
    srq_req <= 1'b1;
    cyc(10);
    chk(8'(srq_f), 8'h01);
    chk(status & 8'h80, 8'h80);
    cfg(5'h00, 8'h00);
    chk(8'(srq_f), 8'h00);
    srq_req <= 1'b0;
    cfg(5'h02, 8'h10);
    chk(8'(lppb_gpio_if_inst.handshake_polarity_out), 8'h01);
  endtask : t_cfg

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    msg_v = 1'b0;
    msg_c = LPPB_MSG_NONE;
    cfg_wr = 1'b0;
    cfg_idx = 5'h00;
    cfg_d = 8'h00;
    rx_v = 1'b0;
    rx_d = 8'h00;
    tx_rdy = 1'b0;
    h_tx_v = 1'b0;
    h_tx_d = 8'h00;
    srq_req = 1'b0;
    cyc(5);
    rst <= 1'b0;
    t_start();
    t_events();
    t_out();
    t_in();
    t_cfg();
    finish_test();
  end
endmodule : lppb_tb_top
